// ==== hw/ilgms_pkg.sv ====
// Package with register map, reset values and carriers for the lock gate and monitor select bank.
package ilgms_pkg;
  localparam int ADDR_W = 8;
  localparam int INPUTS = 14;
  localparam int UPPER_FIRST = 8;
  localparam int UPPER_COUNT = 6;
  localparam logic [7:0] REMOTE_VALID_MASK_UPPER_IDX = 8'h31;
  localparam logic [7:0] MONITOR_LOOP_SOURCE_SELECT_IDX = 8'h33;
  localparam logic [7:0] REMOTE_VALID_MASK_UPPER_RESET = 8'h3f;
  localparam logic [7:0] MONITOR_LOOP_SOURCE_SELECT_RESET = 8'h0f;
  localparam logic [3:0] SEL_NONE_LOW = 4'h0;
  localparam logic [3:0] SEL_NONE_HIGH = 4'hf;
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST = 4'he;

  typedef struct packed {
    logic [5:0] lock_allowed;
    logic [3:0] monitor_code;
  } ilgms_cfg_s;
endpackage

// ==== hw/ilgms_regs.sv ====
// Storage of the two configuration registers with registered read data.
`timescale 1ns/1ps
module ilgms_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wr_mask,
  input wire logic wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output ilgms_pkg::ilgms_cfg_s cfg,
  output logic [7:0] rd_data
);
  ilgms_pkg::ilgms_cfg_s next_cfg;
  logic [7:0] next_rd_data;

  always_comb begin
    next_cfg = cfg;
    next_rd_data = rd_data;
    if (wr_mask) begin
      next_cfg.lock_allowed = wr_data[5:0];
    end
    if (wr_sel) begin
      next_cfg.monitor_code = wr_data[3:0];
    end
    if (rd_en) begin
      if (rd_addr == ilgms_pkg::REMOTE_VALID_MASK_UPPER_IDX) begin
        next_rd_data = {2'h0, cfg.lock_allowed};
      end else if (rd_addr == ilgms_pkg::MONITOR_LOOP_SOURCE_SELECT_IDX) begin
        next_rd_data = {4'h0, cfg.monitor_code};
      end else begin
        next_rd_data = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg.lock_allowed <= ilgms_pkg::REMOTE_VALID_MASK_UPPER_RESET[5:0];
      cfg.monitor_code <= ilgms_pkg::MONITOR_LOOP_SOURCE_SELECT_RESET[3:0];
      rd_data <= 8'h00;
    end else begin
      cfg <= next_cfg;
      rd_data <= next_rd_data;
    end
  end
endmodule // ilgms_regs

// ==== hw/ilgms_top.sv ====
// Wishbone register bank gating lock eligibility and selecting the monitor loop source.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
// Functional notes
// - Mask bits 5..0 gate inputs fourteen..nine.
// - Eligible needs internal validity, plus the mask bit for inputs fourteen..nine.
// - Mask register resets to 0x3f.
// - Select register low nibble, resets 0x0f.
// - Codes 1..14 route that input; 0/15 none.
module ilgms_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [13:0] input_valid,
  output logic [13:0] lock_eligible,
  output logic [13:0] monitor_route,
  output logic monitor_route_valid
);
  ilgms_pkg::ilgms_cfg_s cfg;
  logic [7:0] rd_byte;
  logic req;
  logic rd_pending;
  logic next_ack;
  logic next_rd_pending;
  logic [31:0] next_dat;
  logic [13:0] valid_meta;
  logic [13:0] valid_sync;
  logic [13:0] next_eligible;
  logic [13:0] next_route;
  logic next_route_valid;
  logic [13:0] mask_full;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !rd_pending;

  ilgms_regs ilgms_regs_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_mask(req && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == ilgms_pkg::REMOTE_VALID_MASK_UPPER_IDX),
    .wr_sel(req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == ilgms_pkg::MONITOR_LOOP_SOURCE_SELECT_IDX),
    .wr_data(wb_dat_i[7:0]),
    .rd_en(req && !wb_we_i),
    .rd_addr(wb_adr_i),
    .cfg(cfg),
    .rd_data(rd_byte)
  );

  // Writes ack one cycle after the request, reads two (data is registered).
  always_comb begin
    next_ack = 1'b0;
    next_rd_pending = 1'b0;
    next_dat = wb_dat_o;
    if (req && wb_we_i) begin
      next_ack = 1'b1;
    end else if (req) begin
      next_rd_pending = 1'b1;
    end
    if (rd_pending) begin
      next_ack = 1'b1;
      next_dat = {24'h000000, rd_byte};
    end
  end

  // Lower inputs are always permitted here; their gate lives elsewhere.
  generate
    for (genvar i = 0; i < ilgms_pkg::INPUTS; i++) begin : g_in
      if (i < ilgms_pkg::UPPER_FIRST) begin : g_low
        assign mask_full[i] = 1'b1;
      end else begin : g_up
        assign mask_full[i] = cfg.lock_allowed[i - ilgms_pkg::UPPER_FIRST];
      end
    end
  endgenerate

  always_comb begin
    next_eligible = mask_full & valid_sync;
    next_route = 14'h0000;
    next_route_valid = 1'b0;
    if (cfg.monitor_code >= ilgms_pkg::SEL_FIRST && cfg.monitor_code <= ilgms_pkg::SEL_LAST) begin
      next_route[cfg.monitor_code - 4'h1] = 1'b1;
      next_route_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      rd_pending <= 1'b0;
      wb_dat_o <= 32'h00000000;
      valid_meta <= 14'h0000;
      valid_sync <= 14'h0000;
      lock_eligible <= 14'h0000;
      monitor_route <= 14'h0000;
      monitor_route_valid <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
      rd_pending <= next_rd_pending;
      wb_dat_o <= next_dat;
      valid_meta <= input_valid;
      valid_sync <= valid_meta;
      lock_eligible <= next_eligible;
      monitor_route <= next_route;
      monitor_route_valid <= next_route_valid;
    end
  end
endmodule // ilgms_top

// ==== verification/ilgms_assertions.sv ====
// Checker for read data, lock gating and monitor routing.
`timescale 1ns/1ps
module ilgms_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [13:0] input_valid,
  input wire logic [13:0] lock_eligible,
  input wire logic [13:0] monitor_route,
  input wire logic monitor_route_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  mask_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h31
    |-> wb_dat_o[31:6] == '0) else $error("mask read upper bits set");
  gate_valid_a: assert property ((lock_eligible & ~$past(input_valid, 3)) == '0)
    else $error("eligible without validity");
  mask_gate_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h31
    |=> (lock_eligible[13:8] & ~$past(wb_dat_i[5:0])) == '0)
    else $error("eligible despite clear mask");
  sel_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h33
    |-> wb_dat_o[31:4] == '0) else $error("select read upper bits set");
  route_hot_a: assert property (monitor_route_valid |-> $onehot(monitor_route))
    else $error("route not one-hot");
  route_none_a: assert property (!monitor_route_valid |-> monitor_route == '0)
    else $error("route without flag");
  cover property (wb_ack_o && wb_we_i);
  cover property (monitor_route_valid);
  cover property (lock_eligible[13:8] != 6'h3f);
endmodule // ilgms_assertions
bind ilgms_top ilgms_assertions ilgms_assertions_inst (.*);

// ==== verification/ilgms_top_tb.sv ====
// Self-checking bench for the lock gate and monitor select bank.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module ilgms_top_tb;
  logic sys_clk = 0, reset = 1, cyc = 0, we = 0, ack, rvalid;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rdat, got;
  logic [3:0] sel = '0;
  logic [13:0] valid = '1, elig, route;
  int bad_count = 0, n_tests = 0;
  ilgms_top ilgms_top_inst (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .input_valid(valid), .lock_eligible(elig), .monitor_route(route),
    .monitor_route_valid(rvalid));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] s = 4'h1);
    int i;
    @(posedge sys_clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge sys_clk);
    got = rdat;
    if (i == 20) begin
      bad_count++;
      finish_test();
    end
    cyc <= 0;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 0;
    bus(0, 8'h31, 0);
    `CHK(got, 32'h3f)
    bus(0, 8'h33, 0);
    `CHK(got, 32'h0f)
    `CHK(rvalid, 1'b0)
    bus(1, 8'h33, 8'h05, 4'he);
    bus(0, 8'h33, 0);
    `CHK(got, 32'h0f)
    $display("reset test done");
    bus(1, 8'h31, 8'hff);
    bus(0, 8'h31, 0);
    `CHK(got, 32'h3f)
    bus(1, 8'h31, 8'h2a);
    repeat (4) @(posedge sys_clk);
    `CHK(elig, 14'h2aff)
    valid <= 14'h37fe;
    repeat (4) @(posedge sys_clk);
    `CHK(elig, 14'h22fe)
    bus(1, 8'h32, 8'h55);
    bus(0, 8'h32, 0);
    `CHK(got, 32'h0)
    $display("gate test done");
    bus(1, 8'h34, 8'h01);
    for (int c = 0; c < 16; c++) begin
      bus(1, 8'h33, {4'ha, c[3:0]});
      repeat (2) @(posedge sys_clk);
      `CHK(route, (c inside {[1:14]}) ? 14'h1 << (c - 1) : 14'h0)
      `CHK(rvalid, c inside {[1:14]})
      bus(0, 8'h33, 0);
      `CHK(got, {28'h0, c[3:0]})
    end
    $display("route test done");
    reset <= 1;
    repeat (3) @(posedge sys_clk);
    reset <= 0;
    bus(0, 8'h31, 0);
    `CHK(got, 32'h3f)
    bus(0, 8'h33, 0);
    `CHK(got, 32'h0f)
    $display("second reset test done");
    finish_test();
  end
endmodule // ilgms_top_tb
